// ### bench/des_key_iv_input_loader_bench.sv
// self-checking bench for the key 3, vector and input fifo loader
`timescale 1ns/100ps
`default_nettype none
`include "cipher_loader_regs.vh"
module des_key_iv_input_loader_bench;
  logic        sys_clk_i, rst_i, wr_i, rd_i, go, dma_wr_i, dma_req_o;
  logic        block_take_i, iv_load_i, block_valid_o, triple_o, chain_o, run_o, irq_o;
  logic [5:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, dma_data_i, c, w0, w1;
  logic [63:0] iv_next_i, block_data_o, key3_o, iv_o;
  int          mismatches, num_checks;
  des_key_iv_input_loader DUT (.sys_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .dma_wr_i, .dma_data_i, .dma_req_o, .block_take_i, .iv_load_i, .iv_next_i,
    .block_valid_o, .block_data_o, .key3_o, .iv_o, .triple_o, .chain_o, .run_o, .irq_o);
  dma_feeder feeder (.sys_clk_i, .rst_i, .go_i(go), .req_i(dma_req_o), .push_o(dma_wr_i),
    .word_o(dma_data_i));
  // ----
  // access tasks
  // ----
  function automatic logic [31:0] bsw(input logic [31:0] w);
    bsw = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction
  task automatic close_out;
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask
  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
  endtask
  task automatic take_block(input logic [63:0] exp);
    int n;
    n = 0;
    while (block_valid_o !== 1'b1 && n < 50)
    begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    if (n == 50)
    begin
      mismatches++;
      close_out();
    end
    // hold the block a while before taking it
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk(block_data_o, exp);
    @(posedge sys_clk_i);
    block_take_i <= 1'b1;
    @(posedge sys_clk_i);
    block_take_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic wait_chk(input logic got_now, input logic exp);
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk(irq_o, exp);
  endtask
  initial
  begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  // ----
  // scenarios
  // ----
  initial
  begin
    {rst_i, wr_i, rd_i, go, block_take_i, iv_load_i} = 6'h20;
    addr_i = 6'h00;
    wdata_i = 32'h0;
    iv_next_i = 64'h0;
    mismatches = 0;
    num_checks = 0;
    do_reset();
    rd(`OFF_CONTROL, 32'h0);
    rd(`OFF_KEY3_LEFT, 32'h0);
    wr(`OFF_KEY3_LEFT, 32'h01234567);
    wr(`OFF_CONTROL, 32'h00001000);
    wr(`OFF_KEY3_RIGHT, 32'h89abcdef);
    rd(`OFF_KEY3_RIGHT, 32'hefcdab89);
    chk(key3_o, 64'h00224466eeccaa88);
    wr(`OFF_CONTROL, 32'h00002800);
    wr(`OFF_IV_LEFT, 32'h11223344);
    wr(`OFF_IV_RIGHT, 32'h55667788);
    rd(`OFF_IV_LEFT, 32'h44332211);
    chk(iv_o, 64'h4433221188776655);
    chk(chain_o, 1'b1);
    @(posedge sys_clk_i);
    iv_load_i <= 1'b1;
    iv_next_i <= 64'h0f1e2d3c4b5a6978;
    @(posedge sys_clk_i);
    iv_load_i <= 1'b0;
    rd(`OFF_IV_RIGHT, 32'h4b5a6978);
    chk(iv_o, 64'h0f1e2d3c4b5a6978);
    wr(`OFF_CONTROL, 32'h0);
    rd(`OFF_FILL_LEVEL, 32'h00000020);
    chk(iv_o, 64'h0);
    // every pairing of half order and data swap, triple on odd entries
    for (int i = 0; i < 4; i++)
    begin
      c = 32'h1;
      c[`CTL_DATA_SWAP] = i[1];
      c[`CTL_HALF_ORDER] = i[0];
      c[`CTL_TRIPLE] = i[0];
      wr(`OFF_CONTROL, c);
      w0 = 32'h10203040 + i;
      w1 = 32'hc0d0e0f0 + i;
      wr(`OFF_INPUT_FIFO, w0);
      wr(`OFF_INPUT_FIFO, w1);
      if (i[1])
      begin
        w0 = bsw(w0);
        w1 = bsw(w1);
      end
      take_block(i[0] ? {w1, w0} : {w0, w1});
      chk(triple_o, i[0]);
    end
    rd(`OFF_INPUT_FIFO, 32'h0);
    // overfill with the engine stopped, then raise, mask and clear the interrupt
    wr(`OFF_CONTROL, 32'h00000080);
    for (int i = 0; i < 9; i++)
      wr(`OFF_INPUT_FIFO, 32'h5a5a0000 + i);
    rd(`OFF_FILL_LEVEL, 32'h00000018);
    rd(`OFF_STATUS, 32'h00000007);
    wait_chk(irq_o, 1'b0);
    wr(`OFF_INT_MASK, 32'h00000002);
    wait_chk(irq_o, 1'b1);
    wr(`OFF_STATUS, 32'h00000002);
    wait_chk(irq_o, 1'b0);
    rd(`OFF_STATUS, 32'h00000005);
    do_reset();
    rd(`OFF_FILL_LEVEL, 32'h00000020);
    // dma owns the fifo: the cpu word is dropped, bursts pair up in order
    wr(`OFF_CONTROL, 32'h00000005);
    wr(`OFF_INPUT_FIFO, 32'hdeadbeef);
    #1;
    chk(dma_req_o, 1'b1);
    @(posedge sys_clk_i);
    go <= 1'b1;
    take_block(64'ha0000000a0000001);
    take_block(64'ha0000002a0000003);
    go <= 1'b0;
    close_out();
  end
endmodule // des_key_iv_input_loader_bench
`default_nettype wire

// ### bench/dma_feeder.sv
// dma channel model pushing four-word bursts into the input fifo
`timescale 1ns/100ps
`default_nettype none
module dma_feeder
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        go_i,
  input  wire logic        req_i,
  output var  logic        push_o,
  output var  logic [31:0] word_o
);
  logic [2:0] beat_r;
  logic [7:0] seq_r;
  // beats 0..3 push, 4..7 idle so the registered request can catch up
  always_ff @(posedge sys_clk_i)
    if (rst_i)
    begin
      beat_r <= 3'h0;
      seq_r <= 8'h0;
      push_o <= 1'b0;
      word_o <= 32'h0;
    end
    else
    begin
      push_o <= 1'b0;
      word_o <= ~word_o;
      if (beat_r != 3'h0 || (go_i && req_i))
      begin
        beat_r <= beat_r + 3'h1;
        if (beat_r < 3'h4)
        begin
          push_o <= 1'b1;
          word_o <= {24'ha00000, seq_r};
          seq_r <= seq_r + 8'h1;
        end
      end
    end
endmodule // dma_feeder
`default_nettype wire

// ### bench/loader_assertions.sv
// port-level checks for the key 3, vector and input fifo loader
`timescale 1ns/100ps
`default_nettype none
`include "cipher_loader_regs.vh"
module loader_assertions
(
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic [5:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        dma_req_o,
  input wire logic        block_take_i,
  input wire logic        iv_load_i,
  input wire logic [63:0] iv_next_i,
  input wire logic        block_valid_o,
  input wire logic [63:0] block_data_o,
  input wire logic [63:0] key3_o,
  input wire logic [63:0] iv_o,
  input wire logic        triple_o,
  input wire logic        chain_o,
  input wire logic        run_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic [31:0] ctl_r;
  always_ff @(posedge sys_clk_i)
    if (rst_i)
      ctl_r <= 32'h0;
    else if (wr_i && addr_i == `OFF_CONTROL)
      ctl_r <= wdata_i;
  // key words land swapped on request, parity bits never reach the engine
  function automatic logic [31:0] fix(input logic [31:0] w, input logic s);
    fix = (s ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w) & `PARITY_CLEAR;
  endfunction
  sequence wr_to(logic [5:0] a);
    wr_i && addr_i == a;
  endsequence
  sequence rd_of(logic [5:0] a);
    rd_i && addr_i == a;
  endsequence
  // ----
  // properties
  // ----
  key_left_a: assert property (wr_to(`OFF_KEY3_LEFT) |=> ##1
    key3_o[63:32] == fix($past(wdata_i, 2), $past(ctl_r[`CTL_KEY_SWAP], 2)))
    else $error("key3 left half wrong");
  key_right_a: assert property (wr_to(`OFF_KEY3_RIGHT) |=> ##1
    key3_o[31:0] == fix($past(wdata_i, 2), $past(ctl_r[`CTL_KEY_SWAP], 2)))
    else $error("key3 right half wrong");
  iv_reload_a: assert property (iv_load_i && chain_o |=> ##1 iv_o == $past(iv_next_i, 2))
    else $error("vector not reloaded");
  iv_off_a: assert property (!chain_o |-> iv_o == 64'h0)
    else $error("vector seen outside chaining");
  ctl_copy_a: assert property (wr_to(`OFF_CONTROL) |=> ##1
    triple_o == $past(wdata_i[`CTL_TRIPLE], 2) && run_o == $past(wdata_i[`CTL_RUN], 2))
    else $error("control copy wrong");
  block_hold_a: assert property (block_valid_o && !block_take_i |=>
    block_valid_o && $stable(block_data_o)) else $error("block dropped early");
  fifo_wo_a: assert property (rd_of(`OFF_INPUT_FIFO) |=> rdata_o == 32'h0)
    else $error("fifo offset reads data");
  fill_cap_a: assert property (rd_of(`OFF_FILL_LEVEL) |=> rdata_o[3:0] <= 4'h8)
    else $error("fill above eight");
  dma_req_a: assert property (dma_req_o |-> $past(ctl_r[`CTL_DMA_SEL]))
    else $error("dma request while cpu feeds");
endmodule // loader_assertions
bind des_key_iv_input_loader loader_assertions chk (.sys_clk_i, .rst_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .rdata_o, .dma_req_o, .block_take_i, .iv_load_i, .iv_next_i,
  .block_valid_o, .block_data_o, .key3_o, .iv_o, .triple_o, .chain_o, .run_o);
`default_nettype wire

// ### rtl/byte_swap32.v
// reverses the four bytes of a 32-bit word when enabled
`timescale 1ns/100ps
`default_nettype none

module byte_swap32
(
  input  wire        en_i,
  input  wire [31:0] word_i,
  output wire [31:0] word_o
);

  assign word_o = en_i ? {word_i[7:0], word_i[15:8], word_i[23:16], word_i[31:24]} : word_i;

endmodule // byte_swap32

`default_nettype wire

// ### rtl/cipher_loader_regs.vh
// register offsets, control bit positions and sizes for the cipher key/iv/input loader
`ifndef CIPHER_LOADER_REGS_VH
`define CIPHER_LOADER_REGS_VH

`define ADDR_W            6
`define OFF_CONTROL       6'h00
`define OFF_STATUS        6'h04
`define OFF_INT_MASK      6'h08
`define OFF_KEY3_LEFT     6'h0c
`define OFF_KEY3_RIGHT    6'h10
`define OFF_IV_LEFT       6'h14
`define OFF_IV_RIGHT      6'h18
`define OFF_INPUT_FIFO    6'h1c
`define OFF_FILL_LEVEL    6'h20

`define CTL_RUN           0
`define CTL_DMA_SEL       2
`define CTL_HALF_ORDER    3
`define CTL_TRIPLE        5
`define CTL_PAIR_REQ      7
`define CTL_DATA_SWAP     10
`define CTL_IV_SWAP       11
`define CTL_KEY_SWAP      12
`define CTL_W             13
`define CTL_MASK          13'h1cad
`define CTL_RESET         13'h0000

`define STA_SPACE         0
`define STA_OVERFLOW      1
`define STA_BLOCK         2
`define STA_W             3

`define FIFO_DEPTH        8
`define FIFO_AW           3
`define FIFO_CW           4
`define FIFO_FULL_CNT     4'h8
`define SPACE_QUAD        4'h4
`define SPACE_PAIR        4'h2
`define WORD_ZERO         32'h00000000
`define PARITY_CLEAR      32'hfefefefe

`endif

// ### rtl/des_key_iv_input_loader.v
// key 3, chaining vector and input fifo loading side of the des/3des cipher
//
// What this block does
// - key3 left register holds key bits 1-32
// - key3 right register holds key bits 33-64
// - key byte parity bits ignored by cipher
// - control bit 12 byte-swaps key writes
// - vector used only in chaining mode
// - vector reloaded automatically after each block
// - control bit 11 byte-swaps vector writes
// - input fifo is eight 32-bit words
// - fifo fed by processor or dma
// - bit3 zero: first word is left half
// - bit3 one: first word is right half
// - fifo words least significant byte first
// - control bit 10 byte-swaps fifo writes
// - space flag means four or two free
// - bit5 selects single or triple des
`timescale 1ns/100ps
`default_nettype none
`include "cipher_loader_regs.vh"

module des_key_iv_input_loader
(
  input  wire                 sys_clk_i,
  input  wire                 rst_i,
  // register port
  input  wire [`ADDR_W-1:0]   addr_i,
  input  wire [31:0]          wdata_i,
  input  wire                 wr_i,
  input  wire                 rd_i,
  output reg  [31:0]          rdata_o,
  // dma path into the input fifo
  input  wire                 dma_wr_i,
  input  wire [31:0]          dma_data_i,
  output reg                  dma_req_o,
  // engine side and interrupt
  input  wire                 block_take_i,
  input  wire                 iv_load_i,
  input  wire [63:0]          iv_next_i,
  output reg                  block_valid_o,
  output reg  [63:0]          block_data_o,
  output reg  [63:0]          key3_o,
  output reg  [63:0]          iv_o,
  output reg                  triple_o,
  output reg                  chain_o,
  output reg                  run_o,
  output reg                  irq_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [`CTL_W-1:0]   control_r;
  reg  [31:0]         key3_left_half_r;
  reg  [31:0]         key3_right_half_r;
  reg  [31:0]         init_vector_left_r;
  reg  [31:0]         init_vector_right_r;
  reg  [`STA_W-1:0]   status_r;
  reg  [`STA_W-1:0]   mask_r;
  reg                 space_d_r;
  reg                 chain_mode_r;

  // block assembly
  reg  [31:0]         first_word_r;
  reg                 have_first_r;

  wire                wr_ctl   = wr_i && (addr_i == `OFF_CONTROL);
  wire                wr_sta   = wr_i && (addr_i == `OFF_STATUS);
  wire                wr_mask  = wr_i && (addr_i == `OFF_INT_MASK);
  wire                wr_k3l   = wr_i && (addr_i == `OFF_KEY3_LEFT);
  wire                wr_k3r   = wr_i && (addr_i == `OFF_KEY3_RIGHT);
  wire                wr_ivl   = wr_i && (addr_i == `OFF_IV_LEFT);
  wire                wr_ivr   = wr_i && (addr_i == `OFF_IV_RIGHT);
  wire                wr_fifo_cpu = wr_i && (addr_i == `OFF_INPUT_FIFO);

  wire                dma_sel  = control_r[`CTL_DMA_SEL];

  // ----------------------------------------------------------------
  // byte swap units
  // ----------------------------------------------------------------
  wire [31:0]         key_word;
  wire [31:0]         iv_word;
  wire [31:0]         fifo_word;
  wire [31:0]         fifo_src;
  wire                fifo_push;

  // only the selected master may fill the fifo
  assign fifo_src  = dma_sel ? dma_data_i : wdata_i;
  assign fifo_push = dma_sel ? dma_wr_i : wr_fifo_cpu;

  byte_swap32 u_key_swap
  (
    .en_i   (control_r[`CTL_KEY_SWAP]),
    .word_i (wdata_i),
    .word_o (key_word)
  );

  byte_swap32 u_iv_swap
  (
    .en_i   (control_r[`CTL_IV_SWAP]),
    .word_i (wdata_i),
    .word_o (iv_word)
  );

  // stored word keeps its lowest byte in bits 7:0 unless swapped
  byte_swap32 u_fifo_swap
  (
    .en_i   (control_r[`CTL_DATA_SWAP]),
    .word_i (fifo_src),
    .word_o (fifo_word)
  );

  // ----------------------------------------------------------------
  // input fifo
  // ----------------------------------------------------------------
  wire [31:0]         head_word;
  wire                fifo_empty;
  wire                fifo_full;
  wire [`FIFO_CW-1:0] fifo_count;
  wire                pop;
  wire [`FIFO_CW-1:0] free_words;
  wire [`FIFO_CW-1:0] space_need;
  wire                space_now;
  wire                slot_free;

  input_word_fifo u_fifo
  (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .push_i    (fifo_push),
    .data_i    (fifo_word),
    .pop_i     (pop),
    .data_o    (head_word),
    .empty_o   (fifo_empty),
    .full_o    (fifo_full),
    .count_o   (fifo_count)
  );

  assign free_words = `FIFO_FULL_CNT - fifo_count;
  // request granularity follows the burst size software uses
  assign space_need = control_r[`CTL_PAIR_REQ] ? `SPACE_PAIR : `SPACE_QUAD;
  assign space_now  = (free_words >= space_need);

  // the first half may always move into the assembly stage; the second half
  // only when the output slot is empty or being emptied in this cycle
  assign slot_free = !block_valid_o || block_take_i;
  assign pop       = !fifo_empty && run_o && (!have_first_r || slot_free);

  // ----------------------------------------------------------------
  // block assembly
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      first_word_r  <= `WORD_ZERO;
      have_first_r  <= 1'b0;
      block_valid_o <= 1'b0;
      block_data_o  <= {`WORD_ZERO, `WORD_ZERO};
    end
    else
    begin
      if (block_take_i)
        block_valid_o <= 1'b0;
      if (pop)
      begin
        if (!have_first_r)
        begin
          first_word_r <= head_word;
          have_first_r <= 1'b1;
        end
        else
        begin
          have_first_r  <= 1'b0;
          block_valid_o <= 1'b1;
          if (control_r[`CTL_HALF_ORDER])
            block_data_o <= {head_word, first_word_r};
          else
            block_data_o <= {first_word_r, head_word};
        end
      end
      // clearing run throws away a half-built pair; refill starts on a pair boundary
      if (!run_o)
        have_first_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // software registers and vector update
  // ----------------------------------------------------------------
  // engine reload has priority over a software write in the same cycle
  wire                iv_reload = iv_load_i && chain_mode_r;

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      control_r           <= `CTL_RESET;
      key3_left_half_r    <= `WORD_ZERO;
      key3_right_half_r   <= `WORD_ZERO;
      init_vector_left_r  <= `WORD_ZERO;
      init_vector_right_r <= `WORD_ZERO;
      mask_r              <= {`STA_W{1'b0}};
    end
    else
    begin
      // changes while running are taken as written; software is not to do it
      if (wr_ctl)
        control_r <= wdata_i[`CTL_W-1:0] & `CTL_MASK;
      if (wr_mask)
        mask_r <= wdata_i[`STA_W-1:0];
      if (wr_k3l)
        key3_left_half_r <= key_word;
      if (wr_k3r)
        key3_right_half_r <= key_word;
      if (iv_reload)
      begin
        init_vector_left_r  <= iv_next_i[63:32];
        init_vector_right_r <= iv_next_i[31:0];
      end
      else
      begin
        if (wr_ivl)
          init_vector_left_r <= iv_word;
        if (wr_ivr)
          init_vector_right_r <= iv_word;
      end
    end
  end

  // chaining mode sits just above the masked control field, so the mask never hides it
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
      chain_mode_r <= 1'b0;
    else if (wr_ctl)
      chain_mode_r <= wdata_i[`CTL_W];
  end

  // ----------------------------------------------------------------
  // outputs to the engine
  // ----------------------------------------------------------------
  wire [63:0]         key3_clean;
  wire [63:0]         iv_pair;

  // parity bits are cleared so the engine never sees them
  assign key3_clean = {key3_left_half_r, key3_right_half_r}
                      & {`PARITY_CLEAR, `PARITY_CLEAR};
  // outside chaining the engine sees a zero vector, not a stale one
  assign iv_pair    = chain_mode_r ? {init_vector_left_r, init_vector_right_r}
                                   : {`WORD_ZERO, `WORD_ZERO};

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      key3_o    <= {`WORD_ZERO, `WORD_ZERO};
      iv_o      <= {`WORD_ZERO, `WORD_ZERO};
      triple_o  <= 1'b0;
      chain_o   <= 1'b0;
      run_o     <= 1'b0;
      dma_req_o <= 1'b0;
    end
    else
    begin
      key3_o    <= key3_clean;
      iv_o      <= iv_pair;
      triple_o  <= control_r[`CTL_TRIPLE];
      chain_o   <= chain_mode_r;
      run_o     <= control_r[`CTL_RUN];
      dma_req_o <= dma_sel && space_now;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status: set beats write-one-to-clear
  // ----------------------------------------------------------------
  wire [`STA_W-1:0] sta_set;
  wire [`STA_W-1:0] sta_clr;
  wire              block_done;
  wire              overflow_hit;
  wire              space_rise;

  assign block_done   = pop && have_first_r;
  // a push into a full fifo is dropped, so software must hear about it
  assign overflow_hit = fifo_push && fifo_full;
  assign space_rise   = space_now && !space_d_r;
  assign sta_set      = {block_done, overflow_hit, space_rise};
  assign sta_clr      = wr_sta ? wdata_i[`STA_W-1:0] : {`STA_W{1'b0}};

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      status_r  <= {`STA_W{1'b0}};
      space_d_r <= 1'b0;
      irq_o     <= 1'b0;
    end
    else
    begin
      space_d_r <= space_now;
      status_r  <= (status_r & ~sta_clr) | sta_set;
      irq_o     <= |(status_r & mask_r);
    end
  end

  // ----------------------------------------------------------------
  // read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  wire [31:0]         control_word = {18'h00000, chain_mode_r, control_r};
  wire [31:0]         status_word  = {29'h00000000, status_r};
  wire [31:0]         mask_word    = {29'h00000000, mask_r};
  wire [31:0]         fill_word    = {26'h0000000, space_now, fifo_full, fifo_count};

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
      rdata_o <= `WORD_ZERO;
    else if (rd_i)
    begin
      case (addr_i)
        `OFF_CONTROL    : rdata_o <= control_word;
        `OFF_STATUS     : rdata_o <= status_word;
        `OFF_INT_MASK   : rdata_o <= mask_word;
        `OFF_KEY3_LEFT  : rdata_o <= key3_left_half_r;
        `OFF_KEY3_RIGHT : rdata_o <= key3_right_half_r;
        `OFF_IV_LEFT    : rdata_o <= init_vector_left_r;
        `OFF_IV_RIGHT   : rdata_o <= init_vector_right_r;
        `OFF_FILL_LEVEL : rdata_o <= fill_word;
        // write-only and unmapped offsets read as zero
        default         : rdata_o <= `WORD_ZERO;
      endcase
    end
    else
      rdata_o <= `WORD_ZERO;
  end

endmodule // des_key_iv_input_loader

`default_nettype wire

// ### rtl/input_word_fifo.v
// eight-word, 32-bit input fifo with fill count
`timescale 1ns/100ps
`default_nettype none
`include "cipher_loader_regs.vh"

module input_word_fifo
(
  input  wire                 sys_clk_i,
  input  wire                 rst_i,
  input  wire                 push_i,
  input  wire [31:0]          data_i,
  input  wire                 pop_i,
  output wire [31:0]          data_o,
  output wire                 empty_o,
  output wire                 full_o,
  output wire [`FIFO_CW-1:0]  count_o
);

  reg [31:0]         mem [0:`FIFO_DEPTH-1];
  reg [`FIFO_AW-1:0] wr_ptr_r;
  reg [`FIFO_AW-1:0] rd_ptr_r;
  reg [`FIFO_CW-1:0] count_r;
  wire               do_push;
  wire               do_pop;

  assign empty_o = (count_r == {`FIFO_CW{1'b0}});
  assign full_o  = (count_r == `FIFO_FULL_CNT);
  assign count_o = count_r;
  assign data_o  = mem[rd_ptr_r];
  assign do_push = push_i && !full_o;
  assign do_pop  = pop_i && !empty_o;

  always @(posedge sys_clk_i)
  begin
    if (do_push)
      mem[wr_ptr_r] <= data_i;
  end

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr_r <= {`FIFO_AW{1'b0}};
      rd_ptr_r <= {`FIFO_AW{1'b0}};
      count_r  <= {`FIFO_CW{1'b0}};
    end
    else
    begin
      if (do_push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (do_pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      if (do_push && !do_pop)
        count_r <= count_r + 1'b1;
      else if (do_pop && !do_push)
        count_r <= count_r - 1'b1;
    end
  end

endmodule // input_word_fifo

`default_nettype wire
